// *** rtl/ocp_top.sv ***
// Oscillator power control and divider chain with an APB register window.
//
// What this block does
// - Three independent sources, slow, medium and fast, each separately controlled.
// - First stage divides each source by 1, 2, 4 or 8.
// - Second stage divides by 1,2,3,4,8,12,24,64 onto the matrix line.
// - Fast source has a 100 ns delayed startup enabled by one bit.
// - Matrix power-down/force-on line per source overrides the force-on setting and cell requests.
// - Run decision uses reset, external select, matrix, two settings, cell requests.
// - Reset done with external select stops oscillator; dividers run from pin.
// - Auto mode runs the source only while a counter/delay cell requests it.
// - A source runs only while some consumer of its clock is powered.
`timescale 1ns/10ps
`default_nettype none
module ocp_top
  import ocp_pkg::*;
#(
  parameter int SLOW_HALF_CYC = SLOW_HALF
)
(
  input  wire logic                 clk,
  input  wire logic                 rst_n,
  input  wire logic [7:0]           paddr,
  input  wire logic                 psel,
  input  wire logic                 penable,
  input  wire logic                 pwrite,
  input  wire logic [31:0]          pwdata,
  output logic [31:0]               prdata,
  output logic                      pready,
  output logic                      pslverr,
  input  wire logic                 por_done,
  input  wire logic [NUM_OSC-1:0]   matrix_ctrl,
  input  wire logic [NUM_OSC-1:0]   counter_delay_cells_req,
  input  wire logic [NUM_OSC-1:0]   consumer_on,
  input  wire logic [NUM_OSC-1:0]   ext_clk_pin,
  output logic [NUM_OSC-1:0]        matrix_clk,
  output logic [NUM_OSC-1:0]        osc_running
);
  import ocp_pkg::*;

  logic [CFG_W-1:0] cfg_r [NUM_OSC];
  logic [31:0]      prdata_r;

  wire [NUM_OSC-1:0] run_int;
  wire [NUM_OSC-1:0] logic_on;
  wire [NUM_OSC-1:0] run_q;
  wire [NUM_OSC-1:0] div_out;

  // Register decode.
  wire hit_slow = (paddr == ADDR_CFG_SLOW);
  wire hit_med  = (paddr == ADDR_CFG_MED);
  wire hit_fast = (paddr == ADDR_CFG_FAST);
  wire hit_stat = (paddr == ADDR_STATUS);
  wire hit_any  = hit_slow || hit_med || hit_fast || hit_stat;
  wire setup    = psel && !penable;
  wire wr_acc   = psel && penable && pwrite && hit_any;

  wire [31:0] status_word =
    {23'h000000, div_out, logic_on, run_q};
  wire [31:0] rd_mux =
    hit_slow ? {23'h000000, cfg_r[0]} :
    hit_med  ? {23'h000000, cfg_r[1]} :
    hit_fast ? {23'h000000, cfg_r[2]} :
    hit_stat ? status_word : 32'h00000000;

  // Config is meant to be written once after power-up; the dividers read it live.
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      cfg_r[0] <= CFG_RST;
      cfg_r[1] <= CFG_RST;
      cfg_r[2] <= CFG_RST;
    end
    else if (wr_acc)
    begin
      if (hit_slow)
        cfg_r[0] <= pwdata[CFG_W-1:0];
      if (hit_med)
        cfg_r[1] <= pwdata[CFG_W-1:0];
      if (hit_fast)
        cfg_r[2] <= pwdata[CFG_W-1:0];
    end
  end

  // Read data is captured in the setup cycle so it stands from a flop.
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      prdata_r <= 32'h00000000;
    else if (setup)
      prdata_r <= pwrite ? 32'h00000000 : rd_mux;
  end

  assign prdata  = prdata_r;
  assign pready  = 1'b1;
  assign pslverr = psel && penable && !hit_any;

  genvar i;
  generate
    for (i = 0; i < NUM_OSC; i++)
    begin : g_osc
      localparam logic [15:0] HALF_M1 =
        (i == 0) ? 16'(SLOW_HALF_CYC - 1) :
        (i == 1) ? 16'(MED_HALF - 1) : 16'(FAST_HALF - 1);
      localparam logic [3:0] SU_LOAD = 4'(STARTUP_CYC);

      logic        ext_meta_r;
      logic        ext_sync_r;
      logic        ext_prev_r;
      logic        run_r;
      logic [3:0]  su_cnt_r;
      logic [15:0] half_cnt_r;

      wire [CFG_W-1:0] cfg = cfg_r[i];
      wire ext_sel   = cfg[CFG_EXT_BIT];
      wire m_force   = cfg[CFG_MFORCE_BIT];
      wire force_on  = cfg[CFG_FORCE_BIT];
      wire delay_en  = (i == NUM_OSC - 1) && cfg[CFG_DELAY_BIT];

      wire want = matrix_ctrl[i] ? m_force : (force_on || counter_delay_cells_req[i]);
      assign run_int[i]  = por_done && !ext_sel && want && consumer_on[i];
      assign logic_on[i] = por_done && (ext_sel || run_int[i]);
      assign run_q[i]    = run_r;

      wire int_edge = run_r && (su_cnt_r == 4'h0) && (half_cnt_r == HALF_M1);
      wire ext_edge = ext_sync_r ^ ext_prev_r;
      wire src_edge = ext_sel ? ext_edge : int_edge;

      always_ff @(posedge clk)
      begin
        if (!rst_n)
        begin
          ext_meta_r <= 1'b0;
          ext_sync_r <= 1'b0;
          ext_prev_r <= 1'b0;
        end
        else
        begin
          ext_meta_r <= ext_clk_pin[i];
          ext_sync_r <= ext_meta_r;
          ext_prev_r <= ext_sync_r;
        end
      end

      always_ff @(posedge clk)
      begin
        if (!rst_n)
        begin
          run_r    <= 1'b0;
          su_cnt_r <= 4'h0;
        end
        else
        begin
          run_r <= run_int[i];
          if (run_int[i] && !run_r)
            su_cnt_r <= delay_en ? SU_LOAD : 4'h0;
          else if (su_cnt_r != 4'h0)
            su_cnt_r <= su_cnt_r - 4'h1;
        end
      end

      always_ff @(posedge clk)
      begin
        if (!rst_n || !run_r || (su_cnt_r != 4'h0) || half_cnt_r == HALF_M1)
          half_cnt_r <= 16'h0000;
        else
          half_cnt_r <= half_cnt_r + 16'h0001;
      end

      ocp_div u_div (
        .clk      (clk),
        .rst_n    (rst_n),
        .run      (logic_on[i]),
        .src_edge (src_edge),
        .pre_sel  (cfg[CFG_PRE_LSB +: 2]),
        .post_sel (cfg[CFG_POST_LSB +: 3]),
        .div_clk  (div_out[i])
      );
    end
  endgenerate

  assign matrix_clk  = div_out;
  assign osc_running = run_q;

endmodule : ocp_top
`default_nettype wire

// *** inc/ocp_pkg.sv ***
// Constants shared by the oscillator divider and power control block.
package ocp_pkg;

  localparam int NUM_OSC = 3;

  // Register byte offsets on the APB window.
  localparam logic [7:0] ADDR_CFG_SLOW = 8'h00;
  localparam logic [7:0] ADDR_CFG_MED  = 8'h04;
  localparam logic [7:0] ADDR_CFG_FAST = 8'h08;
  localparam logic [7:0] ADDR_STATUS   = 8'h0c;

  // Configuration word field positions.
  localparam int CFG_W          = 9;
  localparam int CFG_PRE_LSB    = 0;
  localparam int CFG_POST_LSB   = 2;
  localparam int CFG_EXT_BIT    = 5;
  localparam int CFG_MFORCE_BIT = 6;
  localparam int CFG_FORCE_BIT  = 7;
  localparam int CFG_DELAY_BIT  = 8;
  localparam logic [CFG_W-1:0] CFG_RST = 9'h000;

  // Status word field positions.
  localparam int ST_RUN_LSB   = 0;
  localparam int ST_LOGIC_LSB = 3;
  localparam int ST_CLK_LSB   = 6;

  // Clock rate and nominal source frequencies.
  localparam int CLK_HZ  = 50_000_000;
  localparam int CLK_MHZ = 50;
  localparam int SLOW_HZ = 2_048;
  localparam int MED_HZ  = 2_048_000;
  localparam int FAST_HZ = 25_000_000;

  // Half periods of each source in system clock cycles.
  localparam int SLOW_HALF = CLK_HZ / (2 * SLOW_HZ);
  localparam int MED_HALF  = CLK_HZ / (2 * MED_HZ);
  localparam int FAST_HALF = CLK_HZ / (2 * FAST_HZ);

  // Delayed startup of the fast source, rounded up to whole cycles.
  localparam int STARTUP_NS  = 100;
  localparam int STARTUP_CYC = (STARTUP_NS * CLK_MHZ + 999) / 1000;

  // Second stage ratio for each select code.
  function automatic logic [6:0] ocp_post_ratio(input logic [2:0] sel);
    logic [6:0] r;
    r = 7'h01;
    unique case (sel)
      3'h0: r = 7'h01;
      3'h1: r = 7'h02;
      3'h2: r = 7'h03;
      3'h3: r = 7'h04;
      3'h4: r = 7'h08;
      3'h5: r = 7'h0c;
      3'h6: r = 7'h18;
      3'h7: r = 7'h40;
    endcase
    return r;
  endfunction : ocp_post_ratio

endpackage : ocp_pkg

// *** rtl/ocp_div.sv ***
// Two-stage divider for one clock source.
`timescale 1ns/10ps
`default_nettype none
module ocp_div
  import ocp_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       run,
  input  wire logic       src_edge,
  input  wire logic [1:0] pre_sel,
  input  wire logic [2:0] post_sel,
  output logic            div_clk
);

  logic [2:0] pre_cnt_r;
  logic [5:0] post_cnt_r;
  logic       div_clk_r;

  wire [2:0] pre_max  = 3'((4'h1 << pre_sel) - 4'h1);
  wire       pre_edge = src_edge && (pre_cnt_r == pre_max);
  wire [5:0] post_max = 6'(ocp_post_ratio(post_sel) - 7'h01);
  wire       toggle   = pre_edge && (post_cnt_r == post_max);

  // Counting source edges keeps odd ratios at an even duty cycle.
  // Restart when idle.
  always_ff @(posedge clk)
  begin
    if (!rst_n || !run)
    begin
      pre_cnt_r  <= 3'h0;
      post_cnt_r <= 6'h00;
      div_clk_r  <= 1'b0;
    end
    else if (src_edge)
    begin
      pre_cnt_r <= pre_edge ? 3'h0 : pre_cnt_r + 3'h1;
      if (pre_edge)
        post_cnt_r <= toggle ? 6'h00 : post_cnt_r + 6'h01;
      if (toggle)
        div_clk_r <= ~div_clk_r;
    end
  end

  assign div_clk = div_clk_r;

endmodule : ocp_div
`default_nettype wire

// *** bench/ocp_top_assertions.sv ***
// Port checker for the oscillator control block.
`timescale 1ns/10ps
`default_nettype none
module ocp_chk
  import ocp_pkg::*;
#(parameter int SLOW_HALF_CYC = 4)
(
  input wire logic        clk,
  input wire logic        rst_n,
  input wire logic [7:0]  paddr,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        por_done,
  input wire logic [2:0]  consumer_on,
  input wire logic [2:0]  matrix_clk,
  input wire logic [2:0]  osc_running
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  sequence s_acc;
    psel && penable;
  endsequence
  sequence s_por_off;
    !por_done [*3];
  endsequence
  a_ready_high: assert property (pready)
    else $error("pready low");
  a_err_idle: assert property (!(psel && penable) |-> !pslverr)
    else $error("pslverr outside access");
  a_err_unmapped: assert property (s_acc ##0 paddr > ADDR_STATUS |-> pslverr)
    else $error("unmapped access not refused");
  // Only aligned words inside the window are mapped; other byte offsets are refused.
  a_ok_mapped: assert property (s_acc ##0 (paddr <= ADDR_STATUS && paddr[1:0] == 2'h0)
    |-> !pslverr)
    else $error("mapped access refused");
  a_write_zero: assert property (s_acc ##0 pwrite |-> prdata == 32'h0)
    else $error("write returned data");
  a_por_stops: assert property (!por_done |=> osc_running == 3'h0)
    else $error("oscillator runs in reset");
  a_cons_gate: assert property ((osc_running & ~$past(consumer_on)) == 3'h0)
    else $error("oscillator runs without consumer");
  a_clk_off: assert property (s_por_off |-> matrix_clk == 3'h0)
    else $error("divider not cleared");
endmodule : ocp_chk
bind ocp_top ocp_chk #(.SLOW_HALF_CYC(SLOW_HALF_CYC)) u_chk (.clk(clk), .rst_n(rst_n),
  .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .por_done(por_done), .consumer_on(consumer_on),
  .matrix_clk(matrix_clk), .osc_running(osc_running));
`default_nettype wire

// *** bench/ocp_far.sv ***
// Far-side model: connection matrix lines and counter/delay cells.
`timescale 1ns/10ps
`default_nettype none
module ocp_far
(
  input wire logic       clk,
  input wire logic [2:0] mat_set,
  input wire logic [2:0] req_set,
  input wire logic [2:0] cons_set,
  input wire logic       ext_go,
  output logic [2:0]     matrix_ctrl,
  output logic [2:0]     counter_delay_cells_req,
  output logic [2:0]     consumer_on,
  output logic [2:0]     ext_clk_pin
);
  logic [2:0] div_r = 3'h0;
  initial
  begin
    matrix_ctrl = 3'h0;
    counter_delay_cells_req = 3'h0;
    consumer_on = 3'h0;
    ext_clk_pin = 3'h0;
  end
  always @(posedge clk)
  begin
    matrix_ctrl <= mat_set;
    counter_delay_cells_req <= req_set;
    consumer_on <= cons_set;
    div_r <= div_r + 3'h1;
    if (ext_go && div_r == 3'h7)
      ext_clk_pin[0] <= ~ext_clk_pin[0];
  end
endmodule : ocp_far
`default_nettype wire

// *** bench/test_osc_divider_power_control.sv ***
// Self-checking bench for the oscillator control block.
`timescale 1ns/10ps
`default_nettype none
module test_osc_divider_power_control;
  import ocp_pkg::*;
  logic clk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0, por_done = 0, ext_go = 0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, er;
  logic [2:0] ms = 0, rs = 0, cs = 0, mc, rq, co, ep, matrix_clk, osc_running;
  logic [13:0] tv[8] = '{14'h0c80, 14'h18a0, 14'h1e80, 14'h3a40, 14'h3880, 14'h3c00,
    14'h1800, 14'h1640};
  int num_errors = 0, compares = 0, n, t0, t1, np, nc;
  int post_r[8] = '{1, 2, 3, 4, 8, 12, 24, 64};
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin num_errors++; \
  $display("ERROR %0t: got %0h want %0h", $time, a, b); end end
  always #10 clk = ~clk;
  ocp_top #(.SLOW_HALF_CYC(4)) uut (.clk(clk), .rst_n(rst_n), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .por_done(por_done), .matrix_ctrl(mc), .counter_delay_cells_req(rq),
    .consumer_on(co), .ext_clk_pin(ep), .matrix_clk(matrix_clk), .osc_running(osc_running));
  ocp_far far (.clk(clk), .mat_set(ms), .req_set(rs), .cons_set(cs), .ext_go(ext_go),
    .matrix_ctrl(mc), .counter_delay_cells_req(rq), .consumer_on(co), .ext_clk_pin(ep));
  task complete_run;
    $display("compares %0d errors %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : complete_run
  task apb(input logic [7:0] a, input logic w, input logic [31:0] d);
    int k;
    @(posedge clk);
    psel <= 1; penable <= 0; paddr <= a; pwrite <= w; pwdata <= d;
    @(posedge clk);
    penable <= 1;
    for (k = 0; k < 20; k++)
    begin
      @(posedge clk);
      if (pready === 1'b1) break;
    end
    rd = prdata; er = pslverr;
    psel <= 0; penable <= 0;
    if (k == 20)
    begin
      $display("ERROR %0t: bus hang", $time); num_errors++; complete_run;
    end
  endtask : apb
  task rise(input int i, output int c);
    logic p;
    c = 0; p = matrix_clk[i];
    repeat (4000)
    begin
      @(negedge clk); c++;
      if (matrix_clk[i] === 1'b1 && p === 1'b0) return;
      p = matrix_clk[i];
    end
    $display("ERROR %0t: no clock edge", $time); num_errors++; complete_run;
  endtask : rise
  initial
  begin
    repeat (20) @(posedge clk);
    rst_n <= 1; por_done <= 1;
    for (int a = 0; a < 5; a++)
    begin
      apb(8'(a * 4), 0, 0); `CHK({er, rd}, {a == 4, 32'h0})
    end
    apb(ADDR_CFG_FAST, 1, 32'hffff_ffff); apb(ADDR_CFG_FAST, 0, 0); `CHK(rd, 32'h1ff)
    $display("test registers done");
    foreach (tv[i])
    begin
      por_done <= tv[i][12]; ms <= {1'b0, tv[i][9], 1'b0};
      rs <= {1'b0, tv[i][10], 1'b0}; cs <= {1'b0, tv[i][11], 1'b0};
      apb(ADDR_CFG_MED, 1, 32'(tv[i][8:0])); repeat (4) @(negedge clk);
      `CHK(osc_running, {1'b0, tv[i][13], 1'b0})
      apb(ADDR_STATUS, 0, 0); `CHK(rd[ST_RUN_LSB + 1], tv[i][13])
    end
    $display("test run decision done");
    por_done <= 1; ms <= 0; rs <= 0; cs <= 3'b100;
    for (int p = 0; p < 4; p++)
      for (int s = 0; s < 8; s++)
      begin
        apb(ADDR_CFG_FAST, 1, 0); apb(ADDR_CFG_FAST, 1, 32'({3'b100, s[2:0], p[1:0]}));
        rise(2, n); rise(2, n); `CHK(n, 2 * (1 << p) * post_r[s])
      end
    apb(ADDR_CFG_FAST, 1, 0); apb(ADDR_CFG_FAST, 1, 32'h080); rise(2, t0);
    apb(ADDR_CFG_FAST, 1, 0); apb(ADDR_CFG_FAST, 1, 32'h180); rise(2, t1);
    `CHK(t1 - t0, STARTUP_CYC)
    apb(ADDR_CFG_FAST, 1, 0); apb(ADDR_CFG_FAST, 1, 32'h080); rise(2, n); `CHK(n, t0)
    $display("test dividers done");
    apb(ADDR_CFG_SLOW, 1, 32'h0a0); cs <= 3'b001; ext_go <= 1; np = 0; nc = 0;
    for (int c = 0; c < 100; c++)
    begin
      t0 = ep[0]; t1 = matrix_clk[0];
      if (c == 80) ext_go <= 0;
      @(negedge clk); np += (t0 != ep[0]); nc += (t1 != matrix_clk[0]);
    end
    `CHK(nc, np)
    `CHK(osc_running[0], 1'b0)
    por_done <= 0; repeat (5) @(negedge clk); `CHK(matrix_clk, 3'h0)
    $display("test external clock done");
    complete_run;
  end
endmodule : test_osc_divider_power_control
`default_nettype wire
